// [hdl/fie_gate.sv]
// Link ID authentication and program/erase enable gate in front of the flash sequencer
`timescale 1ns/1ps

// Functional notes
// R1: Compare the 256-bit stored link ID with all eight input words joined.
// R2: Input word k carries ID bits 32k+31 down to 32k.
// R3: Software writes input words in order, word 0 first, word 7 last.
// R4: Status bit 0 reads 0 on match, 1 on mismatch.
// R5: Status bits 31 to 1 always read zero.
// R6: After reset status is 0 for all-ones or all-zeros stored ID, else 1.
// R7: All-ones stored ID keeps status 0 forever, no authentication needed.
// R8: Program and erase allowed only while both enable bits are 1.
// R9: Listed program, erase, check, suspend, resume and setting commands refused while disabled.
// R10: A refused command sets the high-voltage enable error flag.
// R11: Both enable registers reset to zero.
// R12: Enable bits 31 to 1 read zero; software writes zero there.
// R13: Enable registers are read/write 32-bit words, bit 0 enables.
// R14: Status register is read-only, read as a 32-bit word.
// R15: While the error flag is set the sequencer bank counts as busy.
// R16: Comparison is redone once the eighth input word is written.
module fie_gate
	import fie_pkg::*;
#(
	parameter int ID_WORDS = FIE_ID_WORDS
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [FIE_ID_BITS-1:0] stored_id,
	input wire fie_bus_t bus,
	input wire fie_req_t cmd_req,
	input wire logic hv_err_clear,
	output logic [31:0] rdata,
	output logic cmd_accept,
	output fie_cmd_t cmd_code,
	output logic cmd_block,
	output logic pe_enabled,
	output logic bank_busy,
	output logic irq
);
	fie_regs_t r;
	fie_regs_t next_r;
	logic stored_ones;
	logic stored_zeros;
	logic id_match;
	logic is_guarded;
	logic wr_id;
	logic [15:0] id_ofs;
	logic [2:0] word_idx;

	// Stored ID classification and comparison
	assign stored_ones = &stored_id; // R7
	assign stored_zeros = ~|stored_id; // R6
	assign id_match = (r.id_in == stored_id); // R1
	assign id_ofs = bus.addr - FIE_OFS_ID_WORD0;
	assign word_idx = id_ofs[4:2];
	assign wr_id = bus.wr && (bus.addr >= FIE_OFS_ID_WORD0) && (id_ofs[15:2] < 14'(ID_WORDS)) && (id_ofs[1:0] == 2'h0);

	// Commands that need program/erase enabled
	always_comb
	begin
		unique case (cmd_req.code)
			FIE_CMD_PROGRAM, FIE_CMD_MULTI_PROGRAM, FIE_CMD_DMA_PROGRAM,
			FIE_CMD_BLOCK_ERASE, FIE_CMD_AREA_ERASE, FIE_CMD_BLANK_CHECK,
			FIE_CMD_SUSPEND, FIE_CMD_RESUME, FIE_CMD_SET_CONFIG,
			FIE_CMD_SET_PROTECT, FIE_CMD_SET_SECURITY: is_guarded = 1'b1; // R9
			default: is_guarded = 1'b0;
		endcase
	end

	// Next state
	always_comb
	begin
		logic [FIE_IRQ_BITS-1:0] ev;
		ev = '0;
		next_r = r;
		next_r.rdata = 32'h0;
		next_r.cmd_accept = 1'b0;
		next_r.cmd_block = 1'b0;
		// Status taken once after reset, from the stored ID alone
		if (!r.init_done)
		begin
			next_r.init_done = 1'b1;
			next_r.locked = !(stored_ones || stored_zeros); // R6
		end
		// Input words land at their slice; the last word triggers the check, the order tracker is unused
		if (wr_id)
		begin
			next_r.id_in[id_ofs[4:2]*32 +: 32] = bus.wdata; // R2
			next_r.state = FIE_ST_FILL;
			next_r.next_word = 3'(id_ofs[4:2] + 3'h1);
			if (id_ofs[4:2] == 3'(ID_WORDS - 1)) // R16
				next_r.state = FIE_ST_CHECK;
		end
		if (r.state == FIE_ST_CHECK)
		begin
			next_r.locked = !id_match; // R4
			next_r.state = FIE_ST_IDLE;
			ev[FIE_IRQ_AUTH] = 1'b1;
		end
		if (stored_ones)
			next_r.locked = 1'b0; // R7
		// Enable and interrupt register writes; only bit 0 of enables is kept
		if (bus.wr)
		begin
			unique case (bus.addr)
				FIE_OFS_AUTH_STATUS: ; // R14
				FIE_OFS_PE_ENABLE_A: next_r.allow_a = bus.wdata[FIE_BIT_ALLOW]; // R13
				FIE_OFS_PE_ENABLE_B: next_r.allow_b = bus.wdata[FIE_BIT_ALLOW]; // R13
				FIE_OFS_SEQ_STATUS: next_r.hv_err = r.hv_err & ~bus.wdata[FIE_BIT_HVERR];
				FIE_OFS_IRQ_STATUS: next_r.irq_stat = r.irq_stat & ~bus.wdata[FIE_IRQ_BITS-1:0];
				FIE_OFS_IRQ_MASK: next_r.irq_mask = bus.wdata[FIE_IRQ_BITS-1:0];
				default: ;
			endcase
		end
		if (hv_err_clear)
			next_r.hv_err = 1'b0;
		// Command gate; a refusal wins over a same-cycle clear of the flag
		if (cmd_req.valid)
		begin
			next_r.cmd_code = cmd_req.code;
			if (is_guarded && !(r.allow_a && r.allow_b)) // R8
			begin
				next_r.cmd_block = 1'b1;
				next_r.hv_err = 1'b1; // R10
				ev[FIE_IRQ_BLOCKED] = 1'b1;
			end
			else
			begin
				next_r.cmd_accept = 1'b1;
				ev[FIE_IRQ_ACCEPT] = 1'b1;
			end
		end
		next_r.irq_stat = next_r.irq_stat | ev;
		// Reads, one cycle later; unmapped and write-only words read zero
		if (bus.rd)
		begin
			unique case (bus.addr)
				FIE_OFS_AUTH_STATUS: next_r.rdata = {31'h0, r.locked}; // R5
				FIE_OFS_PE_ENABLE_A: next_r.rdata = {31'h0, r.allow_a}; // R12
				FIE_OFS_PE_ENABLE_B: next_r.rdata = {31'h0, r.allow_b}; // R12
				FIE_OFS_SEQ_STATUS: next_r.rdata = {30'h0, r.hv_err, r.hv_err};
				FIE_OFS_IRQ_STATUS: next_r.rdata = {29'h0, r.irq_stat};
				FIE_OFS_IRQ_MASK: next_r.rdata = {29'h0, r.irq_mask};
				default: next_r.rdata = 32'h0;
			endcase
		end
		next_r.pe_enabled = next_r.allow_a && next_r.allow_b; // R8
		next_r.bank_busy = next_r.hv_err; // R15
		next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
	end

	// State register; auth status is a writeless read-only bit
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			r <= '0;
			r.locked <= 1'b1;
			r.allow_a <= FIE_ALLOW_RST; // R11
			r.allow_b <= FIE_ALLOW_RST; // R11
			r.irq_stat <= FIE_IRQ_RST;
			r.irq_mask <= FIE_IRQ_RST;
			r.state <= FIE_ST_IDLE;
		end
		else if (ce)
			r <= next_r;
	end

	assign rdata = r.rdata;
	assign cmd_accept = r.cmd_accept;
	assign cmd_code = r.cmd_code;
	assign cmd_block = r.cmd_block;
	assign pe_enabled = r.pe_enabled;
	assign bank_busy = r.bank_busy;
	assign irq = r.irq;

	// Checks: a refused command raises the error flag and busy
	a_blocked_sets_err: assert property (@(posedge mclk) disable iff (srst) // R10
		ce && cmd_req.valid && is_guarded && !(r.allow_a && r.allow_b) |=> cmd_block && bank_busy)
		else $error("refused command did not raise error");

	// Both enables let a guarded command through
	a_accept_needs_both: assert property (@(posedge mclk) disable iff (srst) // R8
		ce && cmd_req.valid && is_guarded && r.allow_a && r.allow_b |=> cmd_accept && !cmd_block)
		else $error("enabled command not accepted");

	// Status follows the compare taken in the check cycle
	a_status_after_check: assert property (@(posedge mclk) disable iff (srst) // R4
		ce && r.state == FIE_ST_CHECK && !stored_ones |=> r.locked == !$past(id_match))
		else $error("status does not follow compare");

	// An all-ones stored ID never locks once the reset-time status is taken
	a_all_ones_open: assert property (@(posedge mclk) disable iff (srst) // R7
		r.init_done && $stable(stored_id) && stored_ones |-> ##1 !r.locked)
		else $error("all-ones ID left locked");

	// The last word starts the check
	a_last_word_check: assert property (@(posedge mclk) disable iff (srst) // R16
		ce && wr_id && id_ofs[4:2] == 3'(ID_WORDS - 1) |=> r.state == FIE_ST_CHECK)
		else $error("last word did not start check");

	// Status word carries only the lock bit
	a_status_read_word: assert property (@(posedge mclk) disable iff (srst) // R5
		ce && bus.rd && bus.addr == FIE_OFS_AUTH_STATUS |=> rdata == {31'h0, $past(r.locked)})
		else $error("status read wrong");

	// Second enable word reads zero above bit 0
	a_enable_read_zero: assert property (@(posedge mclk) disable iff (srst) // R12
		ce && bus.rd && bus.addr == FIE_OFS_PE_ENABLE_B |=> rdata[31:1] == 31'h0)
		else $error("enable upper bits not zero");

	// Busy shown while the error flag stands
	a_busy_follows_err: assert property (@(posedge mclk) disable iff (srst) // R15
		ce ##1 r.hv_err |-> bank_busy)
		else $error("busy not shown on error");

	// Reset leaves program and erase disabled
	a_reset_disabled: assert property (@(posedge mclk) // R11
		srst |=> !pe_enabled && !r.allow_a && !r.allow_b)
		else $error("enables not cleared by reset");

	// Clock enable low must freeze every bit of state
	a_freeze_holds: assert property (@(posedge mclk) disable iff (srst)
		!ce |=> $stable(r))
		else $error("state moved while clock enable low");

	// Read data stand only in the cycle after a read
	a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (srst)
		ce && !bus.rd |=> rdata == 32'h0)
		else $error("read data not zero outside a read");

	// Verdict pulses only follow a request
	a_verdict_pulse: assert property (@(posedge mclk) disable iff (srst)
		ce && !cmd_req.valid |=> !cmd_accept && !cmd_block)
		else $error("verdict without a request");

	// A command is never both passed and refused
	a_verdict_exclusive: assert property (@(posedge mclk) disable iff (srst)
		!(cmd_accept && cmd_block))
		else $error("accept and block together");

	// Unguarded codes always pass
	a_unguarded_pass: assert property (@(posedge mclk) disable iff (srst) // R9
		ce && cmd_req.valid && !is_guarded |=> cmd_accept)
		else $error("unguarded command refused");

	// The code of each request is kept
	a_code_capture: assert property (@(posedge mclk) disable iff (srst)
		ce && cmd_req.valid |=> cmd_code == $past(cmd_req.code))
		else $error("command code not captured");

	// Enabled output mirrors both enable bits
	a_enabled_level: assert property (@(posedge mclk) disable iff (srst) // R8
		pe_enabled == (r.allow_a && r.allow_b))
		else $error("enabled output wrong");

	// First enable takes bit 0 of a write
	a_enable_a_write: assert property (@(posedge mclk) disable iff (srst) // R13
		ce && bus.wr && bus.addr == FIE_OFS_PE_ENABLE_A |=> r.allow_a == $past(bus.wdata[FIE_BIT_ALLOW]))
		else $error("first enable write lost");

	// Second enable takes bit 0 of a write
	a_enable_b_write: assert property (@(posedge mclk) disable iff (srst) // R13
		ce && bus.wr && bus.addr == FIE_OFS_PE_ENABLE_B |=> r.allow_b == $past(bus.wdata[FIE_BIT_ALLOW]))
		else $error("second enable write lost");

	// First enable reads back in bit 0 only
	a_enable_a_read: assert property (@(posedge mclk) disable iff (srst) // R12
		ce && bus.rd && bus.addr == FIE_OFS_PE_ENABLE_A |=> rdata == {31'h0, $past(r.allow_a)})
		else $error("first enable read wrong");

	// Second enable reads back in bit 0 only
	a_enable_b_read: assert property (@(posedge mclk) disable iff (srst) // R12
		ce && bus.rd && bus.addr == FIE_OFS_PE_ENABLE_B |=> rdata == {31'h0, $past(r.allow_b)})
		else $error("second enable read wrong");

	// Writing the status word changes nothing
	a_status_readonly: assert property (@(posedge mclk) disable iff (srst) // R14
		ce && r.init_done && bus.wr && bus.addr == FIE_OFS_AUTH_STATUS && r.state != FIE_ST_CHECK && !stored_ones
		|=> $stable(r.locked))
		else $error("status word took a write");

	// Past the reset-time status, the lock bit moves only in the check cycle or for an all-ones ID
	a_locked_holds: assert property (@(posedge mclk) disable iff (srst) // R4
		ce && r.init_done && r.state != FIE_ST_CHECK && !stored_ones |=> $stable(r.locked))
		else $error("lock bit moved outside a check");

	// Blank stored ID opens after reset
	a_init_open_blank: assert property (@(posedge mclk) disable iff (srst) // R6
		ce && !r.init_done && (stored_ones || stored_zeros) |=> !r.locked)
		else $error("blank ID locked after reset");

	// Any other stored ID locks after reset
	a_init_locked: assert property (@(posedge mclk) disable iff (srst) // R6
		ce && !r.init_done && !stored_ones && !stored_zeros |=> r.locked)
		else $error("set ID open after reset");

	// The reset-time status is taken only once
	a_init_once: assert property (@(posedge mclk) disable iff (srst)
		r.init_done |=> r.init_done)
		else $error("initial status taken twice");

	// The check lasts one cycle
	a_check_one_cycle: assert property (@(posedge mclk) disable iff (srst) // R16
		ce && r.state == FIE_ST_CHECK && !wr_id |=> r.state == FIE_ST_IDLE)
		else $error("check did not end");

	// Earlier words only fill, they do not check
	a_fill_on_word: assert property (@(posedge mclk) disable iff (srst) // R16
		ce && wr_id && word_idx != 3'(ID_WORDS - 1) |=> r.state == FIE_ST_FILL)
		else $error("early word started a check");

	// Word 0 lands in the lowest ID bits
	a_word0_slice: assert property (@(posedge mclk) disable iff (srst) // R2
		ce && wr_id && word_idx == 3'h0 |=> r.id_in[31:0] == $past(bus.wdata))
		else $error("word 0 misplaced");

	// The last word lands in the highest ID bits
	a_word7_slice: assert property (@(posedge mclk) disable iff (srst) // R2
		ce && wr_id && word_idx == 3'(ID_WORDS - 1) |=> r.id_in[32*ID_WORDS-1 -: 32] == $past(bus.wdata))
		else $error("last word misplaced");

	// Order tracker points past the word just written
	a_word_order_track: assert property (@(posedge mclk) disable iff (srst)
		ce && wr_id |=> r.next_word == 3'($past(word_idx) + 3'h1))
		else $error("word order tracker wrong");

	// A refusal is logged as an event
	a_block_sets_irq: assert property (@(posedge mclk) disable iff (srst) // R10
		ce && cmd_req.valid && is_guarded && !(r.allow_a && r.allow_b) |=> r.irq_stat[FIE_IRQ_BLOCKED])
		else $error("refusal event missing");

	// A pass is logged as an event
	a_accept_sets_irq: assert property (@(posedge mclk) disable iff (srst)
		ce && cmd_req.valid && !is_guarded |=> r.irq_stat[FIE_IRQ_ACCEPT])
		else $error("accept event missing");

	// Interrupt is high exactly while an unmasked event stands
	a_irq_level: assert property (@(posedge mclk) disable iff (srst)
		irq == |(r.irq_stat & r.irq_mask))
		else $error("interrupt level wrong");

	// Writing one clears the refusal event
	a_irq_w1c: assert property (@(posedge mclk) disable iff (srst)
		ce && bus.wr && bus.addr == FIE_OFS_IRQ_STATUS && bus.wdata[FIE_IRQ_BLOCKED] && !cmd_req.valid
		|=> !r.irq_stat[FIE_IRQ_BLOCKED])
		else $error("event not cleared");

	// Mask takes a write
	a_mask_write: assert property (@(posedge mclk) disable iff (srst)
		ce && bus.wr && bus.addr == FIE_OFS_IRQ_MASK |=> r.irq_mask == 3'($past(bus.wdata)))
		else $error("mask write lost");

	// Mask reads back
	a_mask_read: assert property (@(posedge mclk) disable iff (srst)
		ce && bus.rd && bus.addr == FIE_OFS_IRQ_MASK |=> rdata == {29'h0, $past(r.irq_mask)})
		else $error("mask read wrong");

	// Clear pin drops the flag when nothing is refused
	a_err_clear_pin: assert property (@(posedge mclk) disable iff (srst) // R15
		ce && hv_err_clear && !cmd_req.valid |=> !r.hv_err)
		else $error("error flag not cleared");

	// The flag stays until someone clears it
	a_err_sticky: assert property (@(posedge mclk) disable iff (srst) // R10
		ce && r.hv_err && !hv_err_clear && !(bus.wr && bus.addr == FIE_OFS_SEQ_STATUS) |=> r.hv_err)
		else $error("error flag dropped by itself");

	// Busy output mirrors the flag
	a_busy_level: assert property (@(posedge mclk) disable iff (srst) // R15
		bank_busy == r.hv_err)
		else $error("busy differs from flag");

	// Sequencer status shows flag and busy
	a_seq_status_read: assert property (@(posedge mclk) disable iff (srst) // R15
		ce && bus.rd && bus.addr == FIE_OFS_SEQ_STATUS |=> rdata == {30'h0, $past(r.hv_err), $past(r.hv_err)})
		else $error("sequencer status read wrong");

	// Input words are write-only and read zero
	a_id_word_read: assert property (@(posedge mclk) disable iff (srst)
		ce && bus.rd && bus.addr == FIE_OFS_ID_WORD0 |=> rdata == 32'h0)
		else $error("input word read not zero");

	// No word ever drives its reserved upper bits
	a_read_upper_zero: assert property (@(posedge mclk) disable iff (srst) // R5
		rdata[31:3] == 29'h0)
		else $error("reserved read bits set");
endmodule

// [hdl/fie_pkg.sv]
// Package for the flash ID authentication and program/erase enable block
package fie_pkg;
	// Register byte offsets; ID words and the extra status words sit in otherwise free space
	localparam logic [15:0] FIE_OFS_AUTH_STATUS = 16'h03FC;
	localparam logic [15:0] FIE_OFS_PE_ENABLE_A = 16'h3800;
	localparam logic [15:0] FIE_OFS_PE_ENABLE_B = 16'h3804;
	localparam logic [15:0] FIE_OFS_ID_WORD0 = 16'h0380;
	localparam logic [15:0] FIE_OFS_SEQ_STATUS = 16'h3810;
	localparam logic [15:0] FIE_OFS_IRQ_STATUS = 16'h3820;
	localparam logic [15:0] FIE_OFS_IRQ_MASK = 16'h3824;
	// Field positions
	localparam int FIE_BIT_LOCKED = 0;
	localparam int FIE_BIT_ALLOW = 0;
	localparam int FIE_BIT_HVERR = 0;
	localparam int FIE_BIT_BUSY = 1;
	localparam int FIE_IRQ_BLOCKED = 0;
	localparam int FIE_IRQ_AUTH = 1;
	localparam int FIE_IRQ_ACCEPT = 2;
	// Sizes
	localparam int FIE_ID_WORDS = 8;
	localparam int FIE_ID_BITS = 256;
	localparam int FIE_IRQ_BITS = 3;
	// Reset values
	localparam logic FIE_ALLOW_RST = 1'b0;
	localparam logic [2:0] FIE_IRQ_RST = 3'h0;

	// Flash sequencer command codes seen by this gate
	typedef enum logic [3:0] {
		FIE_CMD_PROGRAM = 4'h0,
		FIE_CMD_MULTI_PROGRAM = 4'h1,
		FIE_CMD_DMA_PROGRAM = 4'h2,
		FIE_CMD_BLOCK_ERASE = 4'h3,
		FIE_CMD_AREA_ERASE = 4'h4,
		FIE_CMD_BLANK_CHECK = 4'h5,
		FIE_CMD_SUSPEND = 4'h6,
		FIE_CMD_RESUME = 4'h7,
		FIE_CMD_SET_CONFIG = 4'h8,
		FIE_CMD_SET_PROTECT = 4'h9,
		FIE_CMD_SET_SECURITY = 4'hA,
		FIE_CMD_STATUS_CLEAR = 4'hB,
		FIE_CMD_FORCED_STOP = 4'hC
	} fie_cmd_t;

	// Authentication progress states
	typedef enum logic [1:0] {
		FIE_ST_IDLE = 2'b00,
		FIE_ST_FILL = 2'b01,
		FIE_ST_CHECK = 2'b11
	} fie_state_t;

	// Register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} fie_bus_t;

	// Command request towards the sequencer
	typedef struct packed {
		logic valid;
		fie_cmd_t code;
	} fie_req_t;

	// Whole state of the block
	typedef struct packed {
		logic [FIE_ID_BITS-1:0] id_in;
		logic [2:0] next_word;
		fie_state_t state;
		logic locked;
		logic allow_a;
		logic allow_b;
		logic hv_err;
		logic [FIE_IRQ_BITS-1:0] irq_stat;
		logic [FIE_IRQ_BITS-1:0] irq_mask;
		logic [31:0] rdata;
		logic cmd_accept;
		fie_cmd_t cmd_code;
		logic cmd_block;
		logic irq;
		logic pe_enabled;
		logic bank_busy;
		logic init_done;
	} fie_regs_t;
endpackage

// [verif/fie_gate_tb.sv]
// Self-checking testbench for the link ID gate and the program/erase enables
`timescale 1ns/1ps
module testbench
	import fie_pkg::*;
;
	localparam logic [255:0] ID_A = 256'h01234567_89ABCDEF_FEDCBA98_76543210_0F1E2D3C_4B5A6978_8796A5B4_C3D2E1F0;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hv_err_clear = 1'b0;
	logic ce = 1'b1;
	logic [FIE_ID_BITS-1:0] stored_id = ID_A;
	fie_bus_t bus = '0;
	fie_req_t cmd_req = '0;
	logic [31:0] rdata;
	logic cmd_accept, cmd_block, pe_enabled, bank_busy, irq;
	fie_cmd_t cmd_code;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	fie_gate dut_u (.mclk(mclk), .srst(srst), .ce(ce), .stored_id(stored_id), .bus(bus), .cmd_req(cmd_req),
		.hv_err_clear(hv_err_clear), .rdata(rdata), .cmd_accept(cmd_accept), .cmd_code(cmd_code),
		.cmd_block(cmd_block), .pe_enabled(pe_enabled), .bank_busy(bank_busy), .irq(irq));

	// 100 MHz clock
	initial
	begin
		forever #5 mclk = ~mclk;
	end

	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One-cycle write strobe; a gap cycle follows so strobes never merge
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// Command pulse; the verdict pulse is looked at in its only cycle
	task automatic cmd(input fie_cmd_t c, input logic blk);
		@(posedge mclk);
		cmd_req <= '{valid: 1'b1, code: c};
		@(posedge mclk);
		cmd_req.valid <= 1'b0;
		#1 chk({30'h0, cmd_block, cmd_accept}, {30'h0, blk, !blk});
	endtask

	// Words go in ascending order, then the comparison is allowed to settle
	task automatic load_id(input logic [255:0] v);
		for (int k = 0; k < 8; k++)
			wr(FIE_OFS_ID_WORD0 + 16'(4 * k), v[32 * k +: 32]);
		repeat (3) @(posedge mclk);
	endtask

	task automatic do_reset(input logic [255:0] v);
		@(posedge mclk);
		srst <= 1'b1;
		stored_id <= v;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic clear_err();
		@(posedge mclk);
		hv_err_clear <= 1'b1;
		@(posedge mclk);
		hv_err_clear <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	// Main sequence
	initial
	begin
		do_reset(ID_A);
		rd(FIE_OFS_AUTH_STATUS, 32'h1);
		rd(FIE_OFS_PE_ENABLE_A, 32'h0);
		rd(FIE_OFS_PE_ENABLE_B, 32'h0);
		wr(FIE_OFS_IRQ_MASK, 32'h1);
		for (int c = 0; c <= 10; c++)
			cmd(fie_cmd_t'(c), 1'b1);
		chk({31'h0, bank_busy}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		cmd(FIE_CMD_STATUS_CLEAR, 1'b0);
		cmd(FIE_CMD_FORCED_STOP, 1'b0);
		clear_err();
		chk({31'h0, bank_busy}, 32'h0);
		wr(FIE_OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		rd(FIE_OFS_IRQ_STATUS, 32'h4);
		// Masked event must stay silent
		wr(FIE_OFS_IRQ_MASK, 32'h0);
		cmd(FIE_CMD_PROGRAM, 1'b1);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		clear_err();
		// One enable alone is not enough
		wr(FIE_OFS_PE_ENABLE_A, 32'h1);
		rd(FIE_OFS_PE_ENABLE_A, 32'h1);
		cmd(FIE_CMD_BLOCK_ERASE, 1'b1);
		clear_err();
		wr(FIE_OFS_PE_ENABLE_B, 32'h1);
		repeat (2) @(posedge mclk);
		chk({31'h0, pe_enabled}, 32'h1);
		cmd(FIE_CMD_AREA_ERASE, 1'b0);
		chk({28'h0, cmd_code}, {28'h0, FIE_CMD_AREA_ERASE});
		wr(FIE_OFS_PE_ENABLE_A, 32'h0);
		cmd(FIE_CMD_SET_SECURITY, 1'b1);
		rd(FIE_OFS_SEQ_STATUS, 32'h3);
		wr(FIE_OFS_SEQ_STATUS, 32'h1);
		rd(FIE_OFS_SEQ_STATUS, 32'h0);
		// Clock enable low freezes everything, a refusable command too
		@(posedge mclk);
		ce <= 1'b0;
		cmd_req <= '{valid: 1'b1, code: FIE_CMD_PROGRAM};
		@(posedge mclk);
		cmd_req.valid <= 1'b0;
		#1 chk({30'h0, cmd_block, bank_busy}, 32'h0);
		@(posedge mclk);
		ce <= 1'b1;
		clear_err();
		// Authentication: match, read-only status, word and bit order
		wr(FIE_OFS_IRQ_MASK, 32'h2);
		load_id(ID_A);
		rd(FIE_OFS_AUTH_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h1);
		rd(FIE_OFS_IRQ_MASK, 32'h2);
		wr(FIE_OFS_AUTH_STATUS, 32'hFFFFFFFF);
		rd(FIE_OFS_AUTH_STATUS, 32'h0);
		load_id(ID_A ^ {1'b1, 255'h0});
		rd(FIE_OFS_AUTH_STATUS, 32'h1);
		load_id({ID_A[255:64], ID_A[31:0], ID_A[63:32]});
		rd(FIE_OFS_AUTH_STATUS, 32'h1);
		rd(FIE_OFS_ID_WORD0, 32'h0);
		rd(16'h1000, 32'h0);
		// Blank stored IDs
		do_reset({256{1'b1}});
		rd(FIE_OFS_AUTH_STATUS, 32'h0);
		load_id(ID_A);
		rd(FIE_OFS_AUTH_STATUS, 32'h0);
		do_reset(256'h0);
		rd(FIE_OFS_AUTH_STATUS, 32'h0);
		final_report();
	end
endmodule
